// file: core/frtfc_timer.sv
/*
  free-running 16-bit timer with compare flags, overflow flag, capture control and apb slave.
  assumes an apb master on pclk; capture and count pins are synchronous to pclk.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
//
// Contract
// - match flag a sets when counter equals compare value a.
// - match flag b sets when counter equals compare value b.
// - wrap flag sets when counter goes from ffff to zero; the code does not set it when clear-on-match-a zeroes the counter at ffff.
// - match flag a clears only after a read seeing one, then write zero.
// - match flag b clears only after a read seeing one, then write zero.
// - wrap flag clears only after a read seeing one, then write zero.
// - writing one to a status flag does nothing.
// - clear-on-match-a bit set zeroes the counter on match a.
// - per-channel edge select: zero falling, one rising.
// - buffer enable a makes capture c the buffer of capture a.
// - buffer enable b makes capture d the buffer of capture b.
// - clock select picks div2, div8, div32 or external pin rising edges.
// - edge, buffer and clock select bits reset to zero.
// - with buffer a, a c edge sets flag c without loading capture c.
`timescale 1ns/100ps
`default_nettype none
`include "frtfc_params.svh"

module frtfc_timer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_pin_a,
  input  wire logic        capture_pin_b,
  input  wire logic        capture_pin_c,
  input  wire logic        capture_pin_d,
  input  wire logic        external_count_pin,
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  frtfc_pkg::frtfc_ctrl_t ctrl_reg;
  frtfc_pkg::frtfc_caps_t caps;
  frtfc_pkg::frtfc_arm_t  arm_a_reg;
  frtfc_pkg::frtfc_arm_t  arm_b_reg;
  frtfc_pkg::frtfc_arm_t  arm_w_reg;
  logic [15:0] free_running_counter;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic        match_flag_a;
  logic        match_flag_b;
  logic        counter_wrap_flag;
  logic        clear_on_match_a;
  logic [3:0]  capture_flags;
  logic [3:0]  capture_events;
  logic [6:0]  irq_mask_reg;
  logic [4:0]  prescale_reg;
  logic        ext_prev_reg;
  logic        tick;
  logic        hit_a;
  logic        hit_b;
  logic        wrap;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rdata_next;
  logic [7:0]  status_view;

  function automatic logic sel(input logic [11:0] a, input logic [11:0] ofs);
    sel = (a == ofs);
  endfunction : sel

  // a clear takes effect only if the preceding read saw the flag set
  function automatic frtfc_pkg::frtfc_arm_t arm_next(input frtfc_pkg::frtfc_arm_t cur, input logic rd,
                                                     input logic wr, input logic flag);
    arm_next = cur;
    if (rd)
      arm_next = flag ? frtfc_pkg::FRTFC_ARM_SET : frtfc_pkg::FRTFC_ARM_IDLE;
    else if (wr)
      arm_next = frtfc_pkg::FRTFC_ARM_IDLE;
  endfunction : arm_next

  function automatic logic clr_ok(input frtfc_pkg::frtfc_arm_t cur, input logic wr, input logic bitval);
    case (cur)
      frtfc_pkg::FRTFC_ARM_SET:  clr_ok = wr && !bitval;
      frtfc_pkg::FRTFC_ARM_IDLE: clr_ok = 1'b0;
      default:                   clr_ok = 1'b0;
    endcase
  endfunction : clr_ok

  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign addr_ok = sel(paddr, `FRTFC_OFS_STATUS) || sel(paddr, `FRTFC_OFS_CTRL) ||
                   sel(paddr, `FRTFC_OFS_COUNTER) || sel(paddr, `FRTFC_OFS_CMP_A) ||
                   sel(paddr, `FRTFC_OFS_CMP_B) || sel(paddr, `FRTFC_OFS_CAP_A) ||
                   sel(paddr, `FRTFC_OFS_CAP_B) || sel(paddr, `FRTFC_OFS_CAP_C) ||
                   sel(paddr, `FRTFC_OFS_CAP_D) || sel(paddr, `FRTFC_OFS_CAPFLAG) ||
                   sel(paddr, `FRTFC_OFS_IRQ_MASK);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && penable && !pwrite && addr_ok;

  assign status_view = {4'h0, match_flag_a, match_flag_b, counter_wrap_flag, clear_on_match_a};

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (sel(paddr, `FRTFC_OFS_STATUS))
      rdata_next = {24'h00_0000, status_view};
    else if (sel(paddr, `FRTFC_OFS_CTRL))
      rdata_next = {24'h00_0000, ctrl_reg};
    else if (sel(paddr, `FRTFC_OFS_COUNTER))
      rdata_next = {16'h0000, free_running_counter};
    else if (sel(paddr, `FRTFC_OFS_CMP_A))
      rdata_next = {16'h0000, compare_value_a};
    else if (sel(paddr, `FRTFC_OFS_CMP_B))
      rdata_next = {16'h0000, compare_value_b};
    else if (sel(paddr, `FRTFC_OFS_CAP_A))
      rdata_next = {16'h0000, caps.cap_a};
    else if (sel(paddr, `FRTFC_OFS_CAP_B))
      rdata_next = {16'h0000, caps.cap_b};
    else if (sel(paddr, `FRTFC_OFS_CAP_C))
      rdata_next = {16'h0000, caps.cap_c};
    else if (sel(paddr, `FRTFC_OFS_CAP_D))
      rdata_next = {16'h0000, caps.cap_d};
    else if (sel(paddr, `FRTFC_OFS_CAPFLAG))
      rdata_next = {28'h000_0000, capture_flags};
    else if (sel(paddr, `FRTFC_OFS_IRQ_MASK))
      rdata_next = {25'h000_0000, irq_mask_reg};
  end

  // read data is combinational so a zero-wait read returns the current flags
  assign prdata = rd_en ? rdata_next : 32'h0000_0000;

  // ----------------------------------------------------------------
  // control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= `FRTFC_RST_CTRL;
    else if (wr_en && sel(paddr, `FRTFC_OFS_CTRL))
      ctrl_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clear_on_match_a <= 1'b0;
    else if (wr_en && sel(paddr, `FRTFC_OFS_STATUS))
      clear_on_match_a <= pwdata[`FRTFC_ST_CLR_A];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_value_a <= `FRTFC_RST_CMP;
      compare_value_b <= `FRTFC_RST_CMP;
      irq_mask_reg    <= 7'h00;
    end
    else
    begin
      if (wr_en && sel(paddr, `FRTFC_OFS_CMP_A))
        compare_value_a <= pwdata[15:0];
      if (wr_en && sel(paddr, `FRTFC_OFS_CMP_B))
        compare_value_b <= pwdata[15:0];
      if (wr_en && sel(paddr, `FRTFC_OFS_IRQ_MASK))
        irq_mask_reg <= pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // clock source and counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prescale_reg <= 5'h00;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      prescale_reg <= prescale_reg + 5'h01;
      ext_prev_reg <= external_count_pin;
    end
  end

  always_comb
  begin
    case (ctrl_reg.clk_sel)
      frtfc_pkg::FRTFC_CLK_DIV2:  tick = (prescale_reg & `FRTFC_DIV2_MASK) == `FRTFC_DIV2_MASK;
      frtfc_pkg::FRTFC_CLK_DIV8:  tick = (prescale_reg & `FRTFC_DIV8_MASK) == `FRTFC_DIV8_MASK;
      frtfc_pkg::FRTFC_CLK_DIV32: tick = (prescale_reg & `FRTFC_DIV32_MASK) == `FRTFC_DIV32_MASK;
      frtfc_pkg::FRTFC_CLK_EXT:   tick = external_count_pin && !ext_prev_reg;
      default:                    tick = 1'b0;
    endcase
  end

  assign hit_a = (free_running_counter == compare_value_a);
  assign hit_b = (free_running_counter == compare_value_b);
  assign wrap  = tick && (free_running_counter == `FRTFC_COUNT_MAX) && !(clear_on_match_a && hit_a);

  // software writes to the counter; a write loses to neither tick nor match, it simply wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      free_running_counter <= 16'h0000;
    else if (wr_en && sel(paddr, `FRTFC_OFS_COUNTER))
      free_running_counter <= pwdata[15:0];
    else if (tick && clear_on_match_a && hit_a)
      free_running_counter <= 16'h0000;
    else if (tick)
      free_running_counter <= free_running_counter + 16'h0001;
  end

  // ----------------------------------------------------------------
  // status flags and clear handshake
  // ----------------------------------------------------------------
  logic rd_st;
  logic wr_st;
  assign rd_st = rd_en && sel(paddr, `FRTFC_OFS_STATUS);
  assign wr_st = wr_en && sel(paddr, `FRTFC_OFS_STATUS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_a_reg <= frtfc_pkg::FRTFC_ARM_IDLE;
      arm_b_reg <= frtfc_pkg::FRTFC_ARM_IDLE;
      arm_w_reg <= frtfc_pkg::FRTFC_ARM_IDLE;
    end
    else
    begin
      arm_a_reg <= arm_next(arm_a_reg, rd_st, wr_st, match_flag_a);
      arm_b_reg <= arm_next(arm_b_reg, rd_st, wr_st, match_flag_b);
      arm_w_reg <= arm_next(arm_w_reg, rd_st, wr_st, counter_wrap_flag);
    end
  end

  // a set in the same cycle as a clear wins; writing one never sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_flag_a      <= 1'b0;
      match_flag_b      <= 1'b0;
      counter_wrap_flag <= 1'b0;
    end
    else
    begin
      if (hit_a)
        match_flag_a <= 1'b1;
      else if (clr_ok(arm_a_reg, wr_st, pwdata[`FRTFC_ST_MATCH_A]))
        match_flag_a <= 1'b0;
      if (hit_b)
        match_flag_b <= 1'b1;
      else if (clr_ok(arm_b_reg, wr_st, pwdata[`FRTFC_ST_MATCH_B]))
        match_flag_b <= 1'b0;
      if (wrap)
        counter_wrap_flag <= 1'b1;
      else if (clr_ok(arm_w_reg, wr_st, pwdata[`FRTFC_ST_WRAP]))
        counter_wrap_flag <= 1'b0;
    end
  end

  // capture flags: write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_flags <= 4'h0;
    else if (wr_en && sel(paddr, `FRTFC_OFS_CAPFLAG))
      capture_flags <= capture_events | (capture_flags & ~pwdata[3:0]);
    else
      capture_flags <= capture_flags | capture_events;
  end

  // ----------------------------------------------------------------
  // capture channels and interrupt
  // ----------------------------------------------------------------
  frtfc_capture u_capture
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .capture_pins         ({capture_pin_a, capture_pin_b, capture_pin_c, capture_pin_d}),
    .free_running_counter (free_running_counter),
    .ctrl                 (ctrl_reg),
    .caps                 (caps),
    .capture_events       (capture_events)
  );

  assign irq = |({match_flag_a, match_flag_b, counter_wrap_flag, capture_flags} & irq_mask_reg);

endmodule : frtfc_timer
`default_nettype wire

// file: core/frtfc_params.svh
/*
  register offsets, field positions, reset values and timing counts of the free-running timer block.
  assumes a 32-bit apb with byte addresses, one aligned word per register.
*/
`ifndef FRTFC_PARAMS_SVH
`define FRTFC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FRTFC_OFS_STATUS   12'h000
`define FRTFC_OFS_CTRL     12'h004
`define FRTFC_OFS_COUNTER  12'h008
`define FRTFC_OFS_CMP_A    12'h00C
`define FRTFC_OFS_CMP_B    12'h010
`define FRTFC_OFS_CAP_A    12'h014
`define FRTFC_OFS_CAP_B    12'h018
`define FRTFC_OFS_CAP_C    12'h01C
`define FRTFC_OFS_CAP_D    12'h020
`define FRTFC_OFS_CAPFLAG  12'h024
`define FRTFC_OFS_IRQ_MASK 12'h028

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define FRTFC_ST_MATCH_A   3
`define FRTFC_ST_MATCH_B   2
`define FRTFC_ST_WRAP      1
`define FRTFC_ST_CLR_A     0

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FRTFC_CT_EDGE_A    7
`define FRTFC_CT_EDGE_B    6
`define FRTFC_CT_EDGE_C    5
`define FRTFC_CT_EDGE_D    4
`define FRTFC_CT_BUF_A     3
`define FRTFC_CT_BUF_B     2
`define FRTFC_CT_CKS_HI    1
`define FRTFC_CT_CKS_LO    0

// ----------------------------------------------------------------
// reset values and prescaler
// ----------------------------------------------------------------
`define FRTFC_RST_STATUS   8'h00
`define FRTFC_RST_CTRL     8'h00
`define FRTFC_RST_CMP      16'hFFFF
`define FRTFC_COUNT_MAX    16'hFFFF
`define FRTFC_DIV2_MASK    5'h01
`define FRTFC_DIV8_MASK    5'h07
`define FRTFC_DIV32_MASK   5'h1F

`endif

// file: core/frtfc_pkg.sv
/*
  types shared by the free-running timer block.
  assumes frtfc_params.svh supplies the numbers.
*/
package frtfc_pkg;

  typedef enum logic [1:0] {
    FRTFC_CLK_DIV2  = 2'h0,
    FRTFC_CLK_DIV8  = 2'h1,
    FRTFC_CLK_DIV32 = 2'h2,
    FRTFC_CLK_EXT   = 2'h3
  } frtfc_clk_sel_t;

  typedef struct packed {
    logic [3:0]     edge_rise;
    logic           buf_a;
    logic           buf_b;
    frtfc_clk_sel_t clk_sel;
  } frtfc_ctrl_t;

  typedef struct packed {
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    logic [15:0] cap_c;
    logic [15:0] cap_d;
  } frtfc_caps_t;

  // clear handshake: none armed, or armed by a read that saw the flag at one
  typedef enum logic [1:0] {
    FRTFC_ARM_IDLE = 2'b01,
    FRTFC_ARM_SET  = 2'b10
  } frtfc_arm_t;

endpackage : frtfc_pkg

// file: core/frtfc_capture.sv
/*
  four capture channels: edge detection on the pins and the capture registers with buffer pairing.
  assumes capture pins are synchronous to pclk and the counter value is supplied by the timer.
*/
`timescale 1ns/100ps
`default_nettype none
`include "frtfc_params.svh"

module frtfc_capture
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [3:0]         capture_pins,
  input  wire logic [15:0]        free_running_counter,
  input  var  frtfc_pkg::frtfc_ctrl_t ctrl,
  output var  frtfc_pkg::frtfc_caps_t caps,
  output logic [3:0]              capture_events
);

  logic [3:0] pin_prev_reg;
  logic [3:0] edge_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev_reg <= 4'h0;
    else
      pin_prev_reg <= capture_pins;
  end

  // bit 3 is channel a, bit 0 is channel d, in control-register order
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      edge_hit[i] = ctrl.edge_rise[i] ? (capture_pins[i] & ~pin_prev_reg[i])
                                      : (~capture_pins[i] & pin_prev_reg[i]);
  end

  assign capture_events = edge_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      caps <= '0;
    else
    begin
      // buffer mode: old a moves into c as a takes the new count
      if (edge_hit[3])
      begin
        caps.cap_a <= free_running_counter;
        if (ctrl.buf_a)
          caps.cap_c <= caps.cap_a;
      end
      if (edge_hit[2])
      begin
        caps.cap_b <= free_running_counter;
        if (ctrl.buf_b)
          caps.cap_d <= caps.cap_b;
      end
      // with buffering on, a c or d edge only raises its flag
      if (edge_hit[1] && !ctrl.buf_a)
        caps.cap_c <= free_running_counter;
      if (edge_hit[0] && !ctrl.buf_b)
        caps.cap_d <= free_running_counter;
    end
  end

endmodule : frtfc_capture
`default_nettype wire

// file: tb/frtfc_timer_asserts.sv
/*
  checker for the timer: apb answers, register shadows, sticky flags, irq masking.
  assumes only the ports of frtfc_timer, one pclk domain, zero wait states.
*/
`timescale 1ns/100ps
`default_nettype none
`include "frtfc_params.svh"

module frtfc_timer_asserts
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  logic        acc;
  logic        wr;
  logic        rd;
  logic        st;
  logic [7:0]  ctrl_reg;
  logic        clr_reg;
  logic [15:0] cmp_reg;
  logic [6:0]  mask_reg;
  logic [2:0]  held_reg;

  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign st  = paddr == `FRTFC_OFS_STATUS;

  // held_reg: flags last read as one; only a status write of zero may drop them
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_reg <= 8'h00;
      clr_reg  <= 1'b0;
      cmp_reg  <= 16'hFFFF;
      mask_reg <= 7'h00;
      held_reg <= 3'h0;
    end
    else
    begin
      if (wr && paddr == `FRTFC_OFS_CTRL)
        ctrl_reg <= pwdata[7:0];
      if (wr && paddr == `FRTFC_OFS_CMP_A)
        cmp_reg <= pwdata[15:0];
      if (wr && paddr == `FRTFC_OFS_IRQ_MASK)
        mask_reg <= pwdata[6:0];
      if (wr && st)
        clr_reg <= pwdata[0];
      if (wr && st)
        held_reg <= held_reg & pwdata[3:1];
      else if (rd && st)
        held_reg <= prdata[3:1];
    end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pready; psel |-> pready; endproperty
  a_pready: assert property (p_pready) else $error("pready low in a transfer");
  property p_idle; !(psel && penable) |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("bus outputs active outside access");
  property p_slverr; psel && penable && paddr > `FRTFC_OFS_IRQ_MASK |-> pslverr && prdata == 32'h0; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_ctrl; rd && paddr == `FRTFC_OFS_CTRL |-> prdata == {24'h0, ctrl_reg}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_clr; rd && st |-> prdata[0] == clr_reg; endproperty
  a_clr: assert property (p_clr) else $error("clear-on-match bit readback wrong");
  property p_held; rd && st |-> (prdata[3:1] & held_reg) == held_reg; endproperty
  a_held: assert property (p_held) else $error("status flag dropped without clear");
  property p_cmp; rd && paddr == `FRTFC_OFS_CMP_A |-> prdata == {16'h0, cmp_reg}; endproperty
  a_cmp: assert property (p_cmp) else $error("compare value readback wrong");
  property p_irq; mask_reg == 7'h00 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq high while all masked");
endmodule : frtfc_timer_asserts

bind frtfc_timer frtfc_timer_asserts frtfc_timer_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: tb/frtfc_pins_model.sv
/*
  far side of the timer: four capture pins and the external count pin.
  assumes the bench commands levels; they change just after a pclk edge.
*/
`timescale 1ns/100ps
`default_nettype none

module frtfc_pins_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] pin_req,
  input  wire logic       ext_req,
  output logic [3:0]      capture_pins,
  output logic            external_count_pin
);
  // registered so the pins are synchronous to pclk, as the timer assumes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      capture_pins       <= 4'h0;
      external_count_pin <= 1'b0;
    end
    else
    begin
      capture_pins       <= pin_req;
      external_count_pin <= ext_req;
    end
endmodule : frtfc_pins_model
`default_nettype wire

// file: tb/frtfc_timer_tb.sv
/*
  self-checking bench: apb tasks, counter clocks, flags, capture and buffering.
  assumes the pins model on the far side and zero-wait apb answers.
*/
`timescale 1ns/100ps
`default_nettype none
`include "frtfc_params.svh"

module frtfc_timer_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  pin_req;
  logic        ext_req;
  logic [3:0]  pins;
  logic        ext_pin;
  logic [31:0] q;
  logic        slv;
  int          failures;
  int          comparisons;

  frtfc_pins_model frtfc_pins_model_inst (.pclk(pclk), .presetn(presetn), .pin_req(pin_req),
    .ext_req(ext_req), .capture_pins(pins), .external_count_pin(ext_pin));
  frtfc_timer frtfc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin_a(pins[0]), .capture_pin_b(pins[1]), .capture_pin_c(pins[2]), .capture_pin_d(pins[3]),
    .external_count_pin(ext_pin), .irq(irq));

  always #20 pclk = ~pclk;

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ----------------------------------------------------------------
  // apb master: one idle cycle after each transfer keeps psel edges clean
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    slv = pslverr;
    if (n == 16)
    begin
      failures++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n)
    begin
      ext_req <= 1'b1;
      @(posedge pclk);
      ext_req <= 1'b0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask : tick

  task automatic pin(input int i, input logic v);
    pin_req[i] <= v;
    repeat (4) @(posedge pclk);
  endtask : pin

  initial
  begin
    repeat (50000) @(posedge pclk);
    failures++;
    stop_test();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_req = 4'h0;
    ext_req = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`FRTFC_OFS_CTRL, 32'h0);
    rd(`FRTFC_OFS_STATUS, 32'h0);
    rd(`FRTFC_OFS_CMP_A, 32'h0000_FFFF);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, slv}, 32'h1);
    for (int c = 0; c < 3; c++)
    begin
      wr(`FRTFC_OFS_CTRL, c);
      rd(`FRTFC_OFS_CTRL, c);
      wr(`FRTFC_OFS_COUNTER, 32'h0);
      repeat (64) @(posedge pclk);
      apb(1'b0, `FRTFC_OFS_COUNTER, 32'h0);
      check({31'h0, q >= (64 >> (2*c+1)) && q <= (68 >> (2*c+1)) + 1}, 32'h1);
    end
    wr(`FRTFC_OFS_CTRL, 32'hF3);
    wr(`FRTFC_OFS_COUNTER, 32'h0);
    tick(5);
    rd(`FRTFC_OFS_COUNTER, 32'h5);
    wr(`FRTFC_OFS_COUNTER, 32'hFFFF);
    tick(1);
    rd(`FRTFC_OFS_COUNTER, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(`FRTFC_OFS_IRQ_MASK, 32'h10);
    check({31'h0, irq}, 32'h1);
    wr(`FRTFC_OFS_STATUS, 32'h0);
    // compares still hold ffff, so both match flags set while the counter sits at the top
    rd(`FRTFC_OFS_STATUS, 32'hE);
    wr(`FRTFC_OFS_STATUS, 32'h2);
    rd(`FRTFC_OFS_STATUS, 32'h2);
    wr(`FRTFC_OFS_STATUS, 32'h0);
    rd(`FRTFC_OFS_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(`FRTFC_OFS_STATUS, 32'hE);
    rd(`FRTFC_OFS_STATUS, 32'h0);
    wr(`FRTFC_OFS_CMP_A, 32'h3);
    wr(`FRTFC_OFS_CMP_B, 32'h2);
    tick(3);
    rd(`FRTFC_OFS_STATUS, 32'hC);
    check({31'h0, irq}, 32'h0);
    wr(`FRTFC_OFS_COUNTER, 32'hA);
    wr(`FRTFC_OFS_STATUS, 32'h0);
    rd(`FRTFC_OFS_STATUS, 32'h0);
    wr(`FRTFC_OFS_COUNTER, 32'h2);
    wr(`FRTFC_OFS_COUNTER, 32'hA);
    wr(`FRTFC_OFS_STATUS, 32'h0);
    rd(`FRTFC_OFS_STATUS, 32'h4);
    for (int k = 0; k < 2; k++)
    begin
      wr(`FRTFC_OFS_STATUS, 1 - k);
      wr(`FRTFC_OFS_COUNTER, 32'h0);
      tick(4);
      rd(`FRTFC_OFS_COUNTER, k ? 32'h4 : 32'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`FRTFC_OFS_CTRL, 32'h3 | (32'h80 >> i));
      wr(`FRTFC_OFS_COUNTER, 16 + i);
      pin(i, 1'b1);
      rd(12'(`FRTFC_OFS_CAP_A + 4*i), 16 + i);
      wr(`FRTFC_OFS_CTRL, 32'h3);
      wr(`FRTFC_OFS_COUNTER, 32 + i);
      pin(i, 1'b0);
      rd(12'(`FRTFC_OFS_CAP_A + 4*i), 32 + i);
    end
    wr(`FRTFC_OFS_CAPFLAG, 32'hF);
    rd(`FRTFC_OFS_CAPFLAG, 32'h0);
    wr(`FRTFC_OFS_CTRL, 32'hFF);
    for (int j = 0; j < 2; j++)
    begin
      wr(`FRTFC_OFS_COUNTER, 60 + j);
      pin(j, 1'b1);
      rd(12'(`FRTFC_OFS_CAP_A + 4*j), 60 + j);
      rd(12'(`FRTFC_OFS_CAP_C + 4*j), 32 + j);
      pin(j + 2, 1'b1);
      rd(12'(`FRTFC_OFS_CAP_C + 4*j), 32 + j);
    end
    rd(`FRTFC_OFS_CAPFLAG, 32'hF);
    wr(`FRTFC_OFS_IRQ_MASK, 32'h0F);
    check({31'h0, irq}, 32'h1);
    stop_test();
  end
endmodule : frtfc_timer_tb
`default_nettype wire
